// ==== hw/psr_press_setup.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Interlock settings: none, always, stop/main, top/main.
// - Setting one restarts without a restart pulse.
// - Restart is low-high-low, high at least minimum.
// - High phases over thirty seconds are discarded.
// - Interlocked stop holds enable low until restart.
// - Enable needs indicator low and start conditions.
// - Start/stop rising edge raises enable when permitted.
// - Drop enable on start/stop fall or main low.
// - Single stroke also drops on top rising.
// - Indicator holds until valid restart; blocks enable.
// - Complement output is inverse of main enable.
// - Always setting arms at start and each stop.
// - Start enable only checked while enable is low.
// - Indicator shown only when main and any used start enable high.
module psr_press_setup
    import psr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire psr_cfg_t cfg,
    input wire psr_in_t pins,
    output logic press_en_q,
    output logic restart_req_q,
    output logic main_en_n_q
);

    // Two-stage synchronisers for the inputs coming from outside
    psr_in_t sync1_q, sync2_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    // Previous synchronised samples for edge detection
    psr_in_t prev_q, prev_d;
    logic boot_q, boot_d;    // First cycles after reset, edges suppressed
    logic [1:0] fill_q, fill_d;    // Sync pipeline still holding reset zeros

    // Free-running millisecond time base
    logic [PSR_MS_CNT_W-1:0] ms_cnt_q, ms_cnt_d;
    logic ms_tick_q, ms_tick_d;

    always_comb begin
        ms_tick_d = 1'b0;
        ms_cnt_d = ms_cnt_q + PSR_MS_CNT_W'(1);
        if (ms_cnt_q == PSR_MS_CNT_W'(PSR_MS_CYCLES - 1)) begin
            ms_cnt_d = '0;
            ms_tick_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_q <= '0;
            ms_tick_q <= 1'b0;
        end else begin
            ms_cnt_q <= ms_cnt_d;
            ms_tick_q <= ms_tick_d;
        end
    end

    // Restart pulse validation
    logic restart_ok;

    psr_pulse_check u_pulse (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ms_tick(ms_tick_q),
        .level(sync2_q.restart),
        .long_pulse(cfg.long_pulse),
        .valid_q(restart_ok)
    );

    // Edge events on the synchronised inputs
    logic ss_rise, ss_fall, main_fall, top_rise;
    logic start_ok, stop_any, arm_now;

    always_comb begin
        // Edges are masked until the sync chain holds real samples, so a pin high at reset is no edge
        ss_rise = boot_q && sync2_q.start_stop && !prev_q.start_stop;
        ss_fall = boot_q && !sync2_q.start_stop && prev_q.start_stop;
        main_fall = boot_q && !sync2_q.main_en && prev_q.main_en;
        top_rise = boot_q && cfg.single_stroke && sync2_q.top && !prev_q.top;
        // Start enable only matters when configured
        start_ok = sync2_q.main_en && (!cfg.start_en_used || sync2_q.start_en);
        // Any stop of a running press
        stop_any = ss_fall || top_rise || !sync2_q.main_en;
        // Which stop causes arm the interlock
        case (cfg.interlock)
            PSR_RI_NONE: arm_now = 1'b0;
            PSR_RI_ALWAYS: arm_now = ss_fall || top_rise || main_fall;
            PSR_RI_STOP_MAIN: arm_now = ss_fall || main_fall;
            PSR_RI_TOP_MAIN: arm_now = top_rise || main_fall;
            default: arm_now = ss_fall || top_rise || main_fall;  // Unknown code acts as safest setting
        endcase
    end

    // Interlock and press enable state
    logic armed_q, armed_d;
    logic press_en_d, restart_req_d, main_en_n_d;

    always_comb begin
        prev_d = sync2_q;
        fill_d = {fill_q[0], 1'b1};
        boot_d = fill_q[1];
        armed_d = armed_q;
        press_en_d = press_en_q;
        // Arming wins over a restart that completes in the same cycle
        if (arm_now) begin
            armed_d = 1'b1;
        end else if (restart_ok) begin
            armed_d = 1'b0;
        end
        if (cfg.interlock == PSR_RI_NONE) begin
            armed_d = 1'b0;
        end
        if (press_en_q) begin
            // Start enable no longer watched while running
            if (stop_any) begin
                press_en_d = 1'b0;
            end
        end else if (ss_rise && start_ok && !armed_q && !arm_now && !top_rise) begin
            // A top rise in the same cycle is a stop and wins over the start
            press_en_d = 1'b1;
        end
        // Main enable low forces the output low at once
        if (!sync2_q.main_en || armed_d) begin
            press_en_d = 1'b0;
        end
        // Indicator shows the interlock only while main enable and any used start enable are high
        restart_req_d = armed_d && start_ok;
        main_en_n_d = !sync2_q.main_en;
    end

    // Registered state and outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= '0;
            fill_q <= '0;
            boot_q <= 1'b0;
            armed_q <= 1'b0;
            press_en_q <= PSR_PRESS_EN_RST;
            restart_req_q <= PSR_RESTART_REQ_RST;
            main_en_n_q <= 1'b1;
        end else begin
            prev_q <= prev_d;
            fill_q <= fill_d;
            boot_q <= boot_d;
            // Settings other than none start armed
            armed_q <= boot_q ? armed_d : (cfg.interlock != PSR_RI_NONE);
            press_en_q <= boot_q ? press_en_d : 1'b0;
            restart_req_q <= restart_req_d;
            main_en_n_q <= main_en_n_d;
        end
    end

endmodule

// ==== common/psr_pkg.sv ====
package psr_pkg;

    // Logic cycle clock
    localparam int unsigned PSR_CLK_HZ = 40000000;
    // One millisecond tick of the time base
    localparam int unsigned PSR_MS_CYCLES = PSR_CLK_HZ / 1000;
    localparam int unsigned PSR_MS_CNT_W = 16;
    // Restart pulse limits in milliseconds
    localparam int unsigned PSR_MIN_SHORT_MS = 100;
    localparam int unsigned PSR_MIN_LONG_MS = 350;
    localparam int unsigned PSR_MAX_S = 30;
    localparam int unsigned PSR_MAX_MS = PSR_MAX_S * 1000;
    localparam int unsigned PSR_PULSE_W = 15;

    // Restart interlock setting codes
    localparam logic [2:0] PSR_RI_NONE = 3'h1;
    localparam logic [2:0] PSR_RI_ALWAYS = 3'h2;
    localparam logic [2:0] PSR_RI_STOP_MAIN = 3'h3;
    localparam logic [2:0] PSR_RI_TOP_MAIN = 3'h4;

    // Reset values of the outputs
    localparam logic PSR_PRESS_EN_RST = 1'b0;
    localparam logic PSR_RESTART_REQ_RST = 1'b0;

    // Static configuration of one block instance
    typedef struct packed {
        logic [2:0] interlock;    // Restart interlock setting 1..4
        logic start_en_used;      // Start enable input present
        logic single_stroke;      // Top-dead-centre monitoring on
        logic long_pulse;         // Minimum pulse 350 ms when set, else 100 ms
    } psr_cfg_t;

    // Live inputs from upstream logic
    typedef struct packed {
        logic start_stop;
        logic main_en;
        logic start_en;
        logic top;
        logic restart;
    } psr_in_t;

endpackage

// ==== hw/psr_pulse_check.sv ====
`timescale 1ns/1ps
// Measures the high phase of the restart input in milliseconds
module psr_pulse_check
    import psr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ms_tick,
    input wire logic level,
    input wire logic long_pulse,
    output logic valid_q
);

    logic level_q, level_d;                  // Previous sample of the level
    logic [PSR_PULSE_W-1:0] len_q, len_d;    // High phase length in ms
    logic over_q, over_d;                    // High phase already too long
    logic valid_d;
    logic [PSR_PULSE_W-1:0] min_ms;

    // Pick the configured minimum
    assign min_ms = long_pulse ? PSR_PULSE_W'(PSR_MIN_LONG_MS) : PSR_PULSE_W'(PSR_MIN_SHORT_MS);

    // Count ms while high, judge on the falling edge
    always_comb begin
        level_d = level;
        len_d = len_q;
        over_d = over_q;
        valid_d = 1'b0;
        if (level && !level_q) begin
            // New high phase starts from zero
            len_d = '0;
            over_d = 1'b0;
        end else if (level && ms_tick) begin
            // Saturating count; the flag remembers the overrun
            if (len_q >= PSR_PULSE_W'(PSR_MAX_MS)) begin
                over_d = 1'b1;
            end else begin
                len_d = len_q + PSR_PULSE_W'(1);
            end
        end else if (!level && level_q) begin
            // Only a full low-high-low with the right length counts
            valid_d = (len_q >= min_ms) && !over_q;
        end
    end

    // Register the pulse state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b1;  // A level high at reset is not a rising edge
            len_q <= '0;
            over_q <= 1'b1;
            valid_q <= 1'b0;
        end else begin
            level_q <= level_d;
            len_q <= len_d;
            over_q <= over_d;
            valid_q <= valid_d;
        end
    end

endmodule

// ==== bench/psr_ctl_model.sv ====
`timescale 1ns/1ps
// Operator controls and upstream monitor; levels move at falling edges
module psr_ctl_model
    import psr_pkg::*;
(
    input wire logic ref_clk,
    output psr_in_t pins
);
    psr_in_t v = '0; // Levels now shown
    assign pins = v;
    // New levels clear of the sampling edge
    task automatic set(input psr_in_t x);
        @(negedge ref_clk);
        v = x;
    endtask
    // Push button: low, high for n cycles, low again
    task automatic push(input int n);
        psr_in_t t;
        t = v;
        t.restart = 1'b1;
        set(t);
        repeat (n) @(negedge ref_clk);
        v.restart = 1'b0;
    endtask
endmodule

// ==== bench/psr_press_setup_assertions.sv ====
`timescale 1ns/1ps
// Port checker; a counter hides history from before reset
module psr_press_setup_checker
    import psr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire psr_cfg_t cfg,
    input wire psr_in_t pins,
    input wire logic press_en_q,
    input wire logic restart_req_q,
    input wire logic main_en_n_q
);
    logic [2:0] up_q; // Edges since reset, saturating
    logic [2:0] up_d;
    logic ok; // Delayed inputs are real
    // Next count
    always_comb begin
        up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    end
    // Count register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 3'h0;
        end else begin
            up_q <= up_d;
        end
    end
    assign ok = (up_q == 3'h7);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_main_inverse: assert property (ok |-> main_en_n_q == !$past(pins.main_en, 3)) else $error("bad complement");
    a_enable_blocked: assert property (press_en_q |-> !restart_req_q) else $error("enable while armed");
    a_main_low_drop: assert property (ok && !$past(pins.main_en, 3) |-> !press_en_q) else $error("main low");
    a_stop_fall_drop: assert property (ok && !$past(pins.start_stop, 3) && $past(pins.start_stop, 4) |-> !press_en_q)
        else $error("stop fall");
    a_top_rise_drop: assert property (ok && cfg.single_stroke && $past(pins.top, 3) && !$past(pins.top, 4)
        |-> !press_en_q) else $error("top rise");
    a_start_cause: assert property ($rose(press_en_q) |-> $past(pins.start_stop, 3) && !$past(pins.start_stop, 4)
        && $past(pins.main_en, 3)) else $error("no start cause");
    a_start_en_gate: assert property ($rose(press_en_q) && cfg.start_en_used |-> $past(pins.start_en, 3))
        else $error("start enable low");
    a_none_quiet: assert property (cfg.interlock == PSR_RI_NONE |-> !restart_req_q) else $error("armed in none");
    a_req_shown: assert property (ok && restart_req_q |-> $past(pins.main_en, 3)) else $error("shown main low");
    c_start: cover property ($rose(press_en_q));
    c_armed: cover property (restart_req_q);
    c_top: cover property (cfg.single_stroke && $fell(press_en_q));
endmodule
bind psr_press_setup psr_press_setup_checker psr_press_setup_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .cfg(cfg), .pins(pins), .press_en_q(press_en_q), .restart_req_q(restart_req_q), .main_en_n_q(main_en_n_q));

// ==== bench/tb_psr_press_setup.sv ====
`timescale 1ns/1ps
// Directed sequences; restart timing is too long for a full pulse here
module tb_psr_press_setup
    import psr_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    psr_cfg_t cfg = '0;
    psr_in_t pins;
    logic press_en_q, restart_req_q, main_en_n_q;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    psr_ctl_model psr_ctl_model_inst (.ref_clk(ref_clk), .pins(pins));
    psr_press_setup psr_press_setup_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg), .pins(pins),
        .press_en_q(press_en_q), .restart_req_q(restart_req_q), .main_en_n_q(main_en_n_q));
    // One comparison
    task automatic chk(input string nm, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask
    // Levels {start_stop,main_en,start_en,top,restart}, then let sync settle
    task automatic go(input psr_in_t x);
        psr_ctl_model_inst.set(x);
        repeat (5) @(negedge ref_clk);
    endtask
    // Reset with a new static setting
    task automatic boot(input psr_cfg_t c);
        psr_ctl_model_inst.set('0);
        rst_n = 1'b0;
        cfg = c;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic end_sim;
        $display("run %0d checks, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard; tests need well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        boot(6'h0e); // No interlock, start enable used, single stroke
        chk("main_en_n_q", 1'b1, main_en_n_q);
        go(5'h08);
        go(5'h18);
        chk("press_en_q", 1'b0, press_en_q);
        go(5'h0c);
        go(5'h1c);
        chk("press_en_q", 1'b1, press_en_q);
        chk("main_en_n_q", 1'b0, main_en_n_q);
        chk("restart_req_q", 1'b0, restart_req_q);
        go(5'h18);
        chk("press_en_q", 1'b1, press_en_q);
        go(5'h1a);
        chk("press_en_q", 1'b0, press_en_q);
        go(5'h0c);
        go(5'h1c);
        chk("press_en_q", 1'b1, press_en_q);
        go(5'h0c);
        chk("press_en_q", 1'b0, press_en_q);
        go(5'h1c);
        go(5'h14);
        chk("press_en_q", 1'b0, press_en_q);
        $display("test no_interlock done");
        for (logic [2:0] k = 3'h2; k <= 3'h4; k++) begin
            boot({k, 3'h0});
            go(5'h08);
            chk("restart_req_q", 1'b1, restart_req_q);
            go(5'h18);
            chk("press_en_q", 1'b0, press_en_q);
            psr_ctl_model_inst.push(10);
            repeat (6) @(negedge ref_clk);
            chk("restart_req_q", 1'b1, restart_req_q);
            go(5'h10);
            chk("restart_req_q", 1'b0, restart_req_q);
            $display("test interlock %0d done", k);
        end
        // Start/stop already high across reset is no rising edge
        rst_n = 1'b0;
        cfg = 6'h08;
        psr_ctl_model_inst.set(5'h18);
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("press_en_q", 1'b0, press_en_q);
        $display("test held start done");
        end_sim();
    end
endmodule
